// *** rtl/hrs_pkg.sv ***
// Constants, register map and state types for the hardware reset sequencer.
// Assumes a single 200 MHz core clock; all long waits count 1 us ticks.
package hrs_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_NS = 5;
    localparam int RST_REJECT_NS = 20;
    localparam int RST_MIN_CYC = (RST_REJECT_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int US_NS = 1000;
    localparam int US_CYC = US_NS / CLK_NS;
    localparam int US_PER_MS = 1000;
    localparam int US_PER_S = 1000000;
    localparam int DEV_WAIT_MS = 1;
    localparam int DASP_MIN_MS = 450;
    localparam int DASP_MAX_S = 5;
    localparam int PDIAG_MAX_S = 31;
    localparam int D1_MAX_S = 30;
    localparam int US_W = 25;
    localparam int DIV_W = 8;
    localparam int FCNT_W = 3;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [5:0] REG_STATUS = 6'h00;
    localparam logic [5:0] REG_ERROR = 6'h04;
    localparam logic [5:0] REG_CONFIG = 6'h08;
    localparam logic [5:0] REG_DEVCTL = 6'h0C;
    localparam logic [5:0] REG_IDW93 = 6'h10;
    localparam logic [5:0] REG_SIG = 6'h14;
    localparam logic [5:0] REG_MODE = 6'h18;

    // ==========================================================
    // Field positions and reset values
    localparam int STAT_BSY = 7;
    localparam int ERR_D0_FAIL = 7;
    localparam int CFG_PKT = 0;
    localparam int CFG_DONE = 1;
    localparam int CFG_PASS = 2;
    localparam int CFG_CODE = 8;
    localparam int DC_SRST = 2;
    localparam int DC_DEV = 4;
    localparam int DC_DRST_CMD = 8;
    localparam int MODE_UDMA = 8;
    localparam int MODE_SAVED = 16;
    localparam int MODE_SVALID = 24;
    localparam logic [7:0] STAT_CLR_ATA = 8'h0D;
    localparam logic [7:0] STAT_CLR_PKT = 8'h7D;
    localparam logic [7:0] MODE_DEF = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h80;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_RELEASE = 3'b001,
        ST_D0_WAIT = 3'b011,
        ST_D0_DASP = 3'b010,
        ST_D0_PDIAG = 3'b110,
        ST_STATUS = 3'b111,
        ST_IDLE = 3'b101,
        ST_D1_DASP = 3'b100
    } hrs_state_e;

    typedef struct packed {
        logic s1;
        logic s2;
        logic [FCNT_W-1:0] cnt;
        logic valid;
    } hrs_filt_s;

    typedef struct packed {
        hrs_state_e state;
        logic pos_s1, pos_s2, dasp_s1, dasp_s2, pdiag_s1, pdiag_s2;
        logic [DIV_W-1:0] us_div;
        logic [US_W-1:0] us_cnt;
        logic is_dev1, dasp_seen, pdiag_hit;
        logic [7:0] stat, err, mode, mode_saved;
        logic saved_valid, udma_en, dev_bit, srst;
        logic pkt_en, diag_done, diag_pass;
        logic [6:0] diag_code;
        logic [15:0] w93;
        logic [31:0] sig, rdata;
        logic waitreq, bus_release, dasp_n, dasp_oe, pdiag_n, pdiag_oe;
        logic diag_start, soft_rst;
    } hrs_core_s;
endpackage : hrs_pkg

// *** rtl/hrs_rst_filter.sv ***
// Glitch filter for the host reset pin.
// Assumes the pin is asynchronous to core_clk_in; power-on counts as a reset.
`timescale 1ns/1ps
module hrs_rst_filter (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Host reset pin, active low
    input wire logic hw_reset_n_in,
    // Valid reset seen and still held
    output logic valid_out
);
    hrs_pkg::hrs_filt_s q, n;

    // ==========================================================
    // Filter
    // A low must be seen on more consecutive samples than a 20 ns pulse can give.
    always_comb begin
        n = q;
        n.s1 = hw_reset_n_in;
        n.s2 = q.s1;
        if (q.s2) begin
            n.cnt = '0;
            n.valid = 1'b0;
        end else if (q.cnt == hrs_pkg::FCNT_W'(hrs_pkg::RST_MIN_CYC - 1)) begin
            n.valid = 1'b1; // R1
        end else begin
            n.cnt = q.cnt + hrs_pkg::FCNT_W'(1);
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= '{s1: 1'b0, s2: 1'b0, cnt: '0, valid: 1'b1};
        end else begin
            q <= n;
        end
    end

    assign valid_out = q.valid;
endmodule : hrs_rst_filter

// *** rtl/hrs_seq.sv ***
// Device-side power-on and hardware reset sequencer with an Avalon-MM register slave.
// Assumes pins pass through board buffers; oe outputs gate the pad drivers.
// Operation
// R1: Ignore reset pulses under 20 ns; always accept 25 us or longer.
// R2: When a valid reset negates, leave reset hold for bus release.
// R3: Within 400 ns of release, float bus signals and set BSY.
// R4: During release, read the Device 0 or Device 1 position input.
// R5: Device 0 goes to DASP wait, Device 1 to DASP assert.
// R6: Device 0 floats DASP and clears DEV within 1 ms.
// R7: Device 0 waits at least 1 ms before sampling DASP.
// R8: Start self-diagnostics and disable every Ultra DMA mode.
// R9: Device 0 samples DASP; asserted moves to PDIAG sampling.
// R10: Sample DASP up to 5 s; then clear error bit 7, set status.
// R11: PDIAG asserted clears error bit 7 and goes to status setting.
// R12: PDIAG still negated at 31 s sets error bit 7, status setting.
// R13: Finish diagnostics, load code into error bits 6:0, load signature.
// R14: Clear the software reset bit during status setting.
// R15: Update identification word 93 with the reset outcome.
// R16: Clear status bits 3,2,0, or 6,5,4,3,2,0 with packet support.
// R17: With packet support restore modes from saved values or defaults.
// R18: Device 0 clears BSY and goes idle as the selected device.
// R19: Device 1 clears DEV, asserts DASP within 400 ms, sets status.
// R20: Device 1 loads its code and asserts PDIAG only on pass.
// R21: Device 1 finishes status setting within 30 s.
// R22: Device 1 clears BSY, idles unselected, drives PDIAG per result.
// R23: A new reset during the sequence restarts it from the start.
// R24: Software reset or reset command is ignored while the sequence runs.
// R25: The host holds reset 25 us, then waits 2 ms before polling BSY.
// R26: All long timeouts count 1 us ticks from the detected negation.
`timescale 1ns/1ps
module hrs_seq #(
    parameter int unsigned DEV_WAIT_US = hrs_pkg::DEV_WAIT_MS * hrs_pkg::US_PER_MS,
    parameter int unsigned DASP_MIN_US = hrs_pkg::DASP_MIN_MS * hrs_pkg::US_PER_MS,
    parameter int unsigned DASP_LIMIT_US = hrs_pkg::DASP_MAX_S * hrs_pkg::US_PER_S,
    parameter int unsigned PDIAG_LIMIT_US = hrs_pkg::PDIAG_MAX_S * hrs_pkg::US_PER_S,
    parameter int unsigned D1_LIMIT_US = hrs_pkg::D1_MAX_S * hrs_pkg::US_PER_S,
    parameter logic [31:0] SIG_ATA = 32'h0000_0001,
    parameter logic [31:0] SIG_PKT = 32'h0000_0002
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Cable pins, asynchronous
    input wire logic hw_reset_n_in,
    input wire logic dev1_sel_in,
    input wire logic dasp_n_in,
    input wire logic pdiag_n_in,
    // Pin drive
    output logic bus_release_out,
    output logic dasp_n_out,
    output logic dasp_oe_out,
    output logic pdiag_n_out,
    output logic pdiag_oe_out,
    // Device core
    output logic busy_out,
    output logic diag_start_out,
    output logic soft_reset_out,
    // Avalon-MM slave
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);
    hrs_pkg::hrs_core_s q, n;
    logic rst_valid;
    logic tick;
    logic fin;
    logic fire;
    logic [31:0] wv;

    function automatic logic hrs_reached(input logic [hrs_pkg::US_W-1:0] c,
                                         input int unsigned lim);
        return 32'(c) >= lim;
    endfunction : hrs_reached

    function automatic logic [31:0] hrs_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : hrs_merge

    hrs_rst_filter u_filt (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .hw_reset_n_in(hw_reset_n_in),
        .valid_out(rst_valid)
    );

    // ==========================================================
    // Helpers
    assign tick = q.us_div == hrs_pkg::DIV_W'(hrs_pkg::US_CYC - 1);
    assign fin = q.diag_done || (q.is_dev1 && hrs_reached(q.us_cnt, D1_LIMIT_US)); // R21
    assign fire = (avs_read_in || avs_write_in) && q.waitreq;

    // ==========================================================
    // Sequencer and register file
    always_comb begin
        n = q;
        wv = '0;
        n.diag_start = 1'b0;
        n.soft_rst = 1'b0;
        n.pos_s1 = dev1_sel_in;
        n.pos_s2 = q.pos_s1;
        n.dasp_s1 = dasp_n_in;
        n.dasp_s2 = q.dasp_s1;
        n.pdiag_s1 = pdiag_n_in;
        n.pdiag_s2 = q.pdiag_s1;
        // Timer restarts at negation, so every long wait is relative to it.
        if (q.state == hrs_pkg::ST_HOLD) begin
            n.us_div = '0; // R26
            n.us_cnt = '0;
        end else if (tick) begin
            n.us_div = '0;
            if (q.us_cnt != '1) begin
                n.us_cnt = q.us_cnt + hrs_pkg::US_W'(1); // R26
            end
        end else begin
            n.us_div = q.us_div + hrs_pkg::DIV_W'(1);
        end
        unique case (q.state)
            hrs_pkg::ST_HOLD: begin
                if (!rst_valid) begin
                    n.state = hrs_pkg::ST_RELEASE; // R2
                end
            end
            hrs_pkg::ST_RELEASE: begin
                n.is_dev1 = q.pos_s2; // R4
                n.udma_en = 1'b0; // R8
                n.diag_done = 1'b0;
                n.diag_start = 1'b1; // R8
                n.dasp_seen = 1'b0;
                n.pdiag_hit = 1'b0;
                n.state = q.pos_s2 ? hrs_pkg::ST_D1_DASP : hrs_pkg::ST_D0_WAIT; // R5
            end
            hrs_pkg::ST_D0_WAIT: begin
                n.dev_bit = 1'b0; // R6
                n.dasp_oe = 1'b0; // R6
                if (hrs_reached(q.us_cnt, DEV_WAIT_US)) begin
                    n.state = hrs_pkg::ST_D0_DASP; // R7
                end
            end
            hrs_pkg::ST_D0_DASP: begin
                if (!q.dasp_s2) begin
                    n.dasp_seen = 1'b1;
                    n.state = hrs_pkg::ST_D0_PDIAG; // R9
                end else if (hrs_reached(q.us_cnt, DASP_LIMIT_US)) begin
                    n.err[hrs_pkg::ERR_D0_FAIL] = 1'b0; // R10
                    n.state = hrs_pkg::ST_STATUS;
                end
            end
            hrs_pkg::ST_D0_PDIAG: begin
                if (!q.pdiag_s2) begin
                    n.err[hrs_pkg::ERR_D0_FAIL] = 1'b0; // R11
                    n.pdiag_hit = 1'b1;
                    n.state = hrs_pkg::ST_STATUS;
                end else if (hrs_reached(q.us_cnt, PDIAG_LIMIT_US)) begin
                    n.err[hrs_pkg::ERR_D0_FAIL] = 1'b1; // R12
                    n.state = hrs_pkg::ST_STATUS;
                end
            end
            hrs_pkg::ST_D1_DASP: begin
                n.dev_bit = 1'b0; // R19
                n.dasp_oe = 1'b1;
                n.dasp_n = 1'b0; // R19
                n.err[hrs_pkg::ERR_D0_FAIL] = 1'b0;
                n.state = hrs_pkg::ST_STATUS;
            end
            hrs_pkg::ST_STATUS: begin
                // Status, signature and BSY all change on one edge, never torn.
                if (fin) begin
                    n.err[6:0] = q.diag_code; // R13 R20
                    n.sig = q.pkt_en ? SIG_PKT : SIG_ATA; // R13
                    n.srst = 1'b0; // R14
                    n.w93 = {11'h000, q.pdiag_hit, q.dasp_seen,
                             q.diag_done & q.diag_pass, q.is_dev1, 1'b1}; // R15
                    n.stat = q.stat & ~(q.pkt_en ? hrs_pkg::STAT_CLR_PKT
                                                 : hrs_pkg::STAT_CLR_ATA); // R16
                    n.stat[hrs_pkg::STAT_BSY] = 1'b0; // R18 R22
                    if (q.pkt_en) begin
                        n.mode = q.saved_valid ? q.mode_saved : hrs_pkg::MODE_DEF; // R17
                    end
                    if (q.is_dev1) begin
                        n.pdiag_oe = 1'b1; // R22
                        n.pdiag_n = ~(q.diag_done & q.diag_pass); // R20 R22
                    end
                    n.bus_release = 1'b0;
                    n.state = hrs_pkg::ST_IDLE; // R21
                end
            end
            hrs_pkg::ST_IDLE: begin
            end
        endcase
        if (rst_valid) begin
            n.state = hrs_pkg::ST_HOLD; // R23
            n.stat[hrs_pkg::STAT_BSY] = 1'b1; // R3
            n.bus_release = 1'b1; // R3
            n.pdiag_oe = 1'b0;
            n.dasp_oe = 1'b0;
        end
        // One wait state: waitrequest drops for the cycle after the request is seen.
        n.waitreq = !fire;
        if (fire && avs_read_in) begin
            unique case (avs_address_in)
                hrs_pkg::REG_STATUS: n.rdata = {16'h0000, 3'b000, q.dasp_seen,
                                                q.is_dev1, q.state, q.stat};
                hrs_pkg::REG_ERROR: n.rdata = {24'h00_0000, q.err};
                hrs_pkg::REG_CONFIG: n.rdata = {17'h0_0000, q.diag_code, 5'b00000,
                                                q.diag_pass, q.diag_done, q.pkt_en};
                hrs_pkg::REG_DEVCTL: n.rdata = {27'h000_0000, q.dev_bit, 1'b0,
                                                q.srst, 2'b00};
                hrs_pkg::REG_IDW93: n.rdata = {16'h0000, q.w93};
                hrs_pkg::REG_SIG: n.rdata = q.sig;
                hrs_pkg::REG_MODE: n.rdata = {7'h00, q.saved_valid, q.mode_saved,
                                              7'h00, q.udma_en, q.mode};
                default: n.rdata = '0;
            endcase
        end
        if (fire && avs_write_in) begin
            wv = hrs_merge('0, avs_writedata_in, avs_byteenable_in);
            unique case (avs_address_in)
                hrs_pkg::REG_STATUS: n.stat[6:0] = wv[6:0];
                hrs_pkg::REG_CONFIG: begin
                    n.pkt_en = wv[hrs_pkg::CFG_PKT];
                    n.diag_done = wv[hrs_pkg::CFG_DONE];
                    n.diag_pass = wv[hrs_pkg::CFG_PASS];
                    n.diag_code = wv[hrs_pkg::CFG_CODE +: 7];
                end
                hrs_pkg::REG_DEVCTL: begin
                    n.dev_bit = wv[hrs_pkg::DC_DEV];
                    // Reset requests during the sequence are dropped, not queued.
                    if (q.state == hrs_pkg::ST_IDLE && !rst_valid) begin
                        n.srst = wv[hrs_pkg::DC_SRST]; // R24
                        n.soft_rst = wv[hrs_pkg::DC_SRST] | wv[hrs_pkg::DC_DRST_CMD];
                    end
                end
                hrs_pkg::REG_MODE: begin
                    n.mode = wv[7:0];
                    n.udma_en = wv[hrs_pkg::MODE_UDMA];
                    n.mode_saved = wv[hrs_pkg::MODE_SAVED +: 8];
                    n.saved_valid = wv[hrs_pkg::MODE_SVALID];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= '0;
            q.state <= hrs_pkg::ST_HOLD;
            q.pos_s1 <= 1'b0;
            q.dasp_s1 <= 1'b1;
            q.dasp_s2 <= 1'b1;
            q.pdiag_s1 <= 1'b1;
            q.pdiag_s2 <= 1'b1;
            q.stat <= hrs_pkg::STAT_RST;
            q.mode <= hrs_pkg::MODE_DEF;
            q.waitreq <= 1'b1;
            q.bus_release <= 1'b1;
            q.dasp_n <= 1'b1;
            q.pdiag_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // Outputs
    assign bus_release_out = q.bus_release;
    assign dasp_n_out = q.dasp_n;
    assign dasp_oe_out = q.dasp_oe;
    assign pdiag_n_out = q.pdiag_n;
    assign pdiag_oe_out = q.pdiag_oe;
    assign busy_out = q.stat[hrs_pkg::STAT_BSY];
    assign diag_start_out = q.diag_start;
    assign soft_reset_out = q.soft_rst;
    assign avs_readdata_out = q.rdata;
    assign avs_waitrequest_out = q.waitreq;

    // ==========================================================
    // Assertions
    a_restart_hold: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R23
        rst_valid |=> q.state == hrs_pkg::ST_HOLD && q.stat[7] && q.bus_release)
        else $error("reset did not restart the sequence");
    a_release_bus: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R3
        q.state == hrs_pkg::ST_RELEASE |-> q.bus_release && q.stat[7] && !q.pdiag_oe)
        else $error("bus not released with BSY set");
    a_leave_hold: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R2
        q.state == hrs_pkg::ST_HOLD && !rst_valid |=> q.state == hrs_pkg::ST_RELEASE)
        else $error("hold state not left after negation");
    a_branch_pos: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R5
        q.state == hrs_pkg::ST_RELEASE && !rst_valid |=>
        q.state == (q.is_dev1 ? hrs_pkg::ST_D1_DASP : hrs_pkg::ST_D0_WAIT) && !q.udma_en)
        else $error("wrong branch after release");
    a_d0_wait_min: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R7
        q.state == hrs_pkg::ST_D0_WAIT && !hrs_reached(q.us_cnt, DEV_WAIT_US) |=>
        q.state inside {hrs_pkg::ST_D0_WAIT, hrs_pkg::ST_HOLD})
        else $error("DASP sampling started too early");
    a_dasp_keep: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R10
        q.state == hrs_pkg::ST_D0_DASP && q.dasp_s2 && !rst_valid &&
        !hrs_reached(q.us_cnt, DASP_MIN_US) |=> q.state == hrs_pkg::ST_D0_DASP)
        else $error("DASP sampling ended before the minimum");
    a_dasp_seen: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R9
        q.state == hrs_pkg::ST_D0_DASP && !q.dasp_s2 && !rst_valid |=>
        q.state == hrs_pkg::ST_D0_PDIAG)
        else $error("asserted DASP not followed");
    a_pdiag_limit: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R12
        q.state == hrs_pkg::ST_D0_PDIAG && q.pdiag_s2 && !rst_valid &&
        hrs_reached(q.us_cnt, PDIAG_LIMIT_US) |=> q.state == hrs_pkg::ST_STATUS && q.err[7])
        else $error("PDIAG timeout not flagged");
    a_status_load: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R13
        q.state == hrs_pkg::ST_STATUS ##1 q.state == hrs_pkg::ST_IDLE |->
        q.err[6:0] == $past(q.diag_code) && !q.srst && !q.stat[7] && q.w93[0])
        else $error("status not loaded on completion");
    a_d1_status: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R19
        q.state == hrs_pkg::ST_D1_DASP && !rst_valid |=>
        q.dasp_oe && !q.dasp_n && !q.dev_bit ##0 q.state == hrs_pkg::ST_STATUS)
        else $error("Device 1 did not assert DASP");
    a_d1_pdiag: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R22
        q.state == hrs_pkg::ST_IDLE && q.is_dev1 |->
        q.pdiag_oe && q.pdiag_n == !q.w93[2])
        else $error("Device 1 PDIAG does not match result");
    a_soft_ignore: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R24
        fire && avs_write_in && q.state != hrs_pkg::ST_IDLE |=> !q.soft_rst)
        else $error("software reset accepted during sequence");
    a_dasp_expire: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R10
        q.state == hrs_pkg::ST_D0_DASP && q.dasp_s2 && !rst_valid &&
        hrs_reached(q.us_cnt, DASP_LIMIT_US) |=> q.state == hrs_pkg::ST_STATUS && !q.err[7])
        else $error("DASP timeout not taken");
    a_pdiag_pass: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R11
        q.state == hrs_pkg::ST_D0_PDIAG && !q.pdiag_s2 && !rst_valid |=>
        q.state == hrs_pkg::ST_STATUS && !q.err[7])
        else $error("asserted PDIAG not followed");
endmodule : hrs_seq

// *** test/hrs_peer.sv ***
// Model of the other drive on the cable, acting as Device 1.
// Assumes DASP- and PDIAG- are wired-low lines with pull-ups.
`timescale 1ns/1ps
module hrs_peer (
    // Clock and host reset pin
    input wire logic core_clk_in,
    input wire logic hw_reset_n_in,
    // Test controls
    input wire logic present_in,
    input wire logic pass_in,
    // Sequencer pin drive
    input wire logic dasp_n_in,
    input wire logic dasp_oe_in,
    input wire logic pdiag_n_in,
    input wire logic pdiag_oe_in,
    // Resolved wire levels
    output logic dasp_n_out,
    output logic pdiag_n_out
);
    // ==========================================================
    // Peer timing
    int cnt = 0;
    logic own_dasp = 1'b0;
    logic own_pdiag = 1'b0;
    // A reasserted reset restarts the peer as well, like a real drive.
    always @(posedge core_clk_in) begin
        if (!hw_reset_n_in || !present_in) begin
            cnt <= 0;
            own_dasp <= 1'b0;
            own_pdiag <= 1'b0;
        end else begin
            cnt <= cnt + 1;
            own_dasp <= cnt >= 400;
            own_pdiag <= pass_in && cnt >= 3000;
        end
    end
    // Released lines float up through the pull-ups.
    assign dasp_n_out = !(own_dasp || (dasp_oe_in && !dasp_n_in));
    assign pdiag_n_out = !(own_pdiag || (pdiag_oe_in && !pdiag_n_in));
endmodule : hrs_peer

// *** test/test_hrs_seq.sv ***
// Testbench for the reset sequencer: register tasks and scripted resets.
// Assumes shortened timeouts of 5 to 40 microseconds and one peer drive.
`timescale 1ns/1ps
module test_hrs_seq;
    // ==========================================================
    // Signals
    logic clk = 0, rst_b = 0, hw_n = 1, sel = 0, prs = 0, ps = 0, rd_en = 0, wr_en = 0;
    logic [5:0] adr = 6'h00;
    logic [3:0] be = 4'hF;
    logic [31:0] wd = 32'h0000_0000, rdd;
    logic rel, dn, doe, pn, poe, bsy, dst, srst, wreq, dasp_w, pdiag_w;
    logic srst_seen = 0, dst_seen = 0;
    int errors = 0, tests_run = 0, cyc = 0, t0;
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (srst === 1'b1) srst_seen = 1;
        if (dst === 1'b1) dst_seen = 1;
    end
    hrs_seq #(.DEV_WAIT_US(5), .DASP_MIN_US(10), .DASP_LIMIT_US(20), .PDIAG_LIMIT_US(40),
        .D1_LIMIT_US(30)) dut (.core_clk_in(clk), .rst_b_in(rst_b), .hw_reset_n_in(hw_n),
        .dev1_sel_in(sel), .dasp_n_in(dasp_w), .pdiag_n_in(pdiag_w), .bus_release_out(rel),
        .dasp_n_out(dn), .dasp_oe_out(doe), .pdiag_n_out(pn), .pdiag_oe_out(poe),
        .busy_out(bsy), .diag_start_out(dst), .soft_reset_out(srst),
        .avs_address_in(adr), .avs_read_in(rd_en), .avs_write_in(wr_en),
        .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdd),
        .avs_waitrequest_out(wreq));
    hrs_peer peer (.core_clk_in(clk), .hw_reset_n_in(hw_n), .present_in(prs), .pass_in(ps),
        .dasp_n_in(dn), .dasp_oe_in(doe), .pdiag_n_in(pn), .pdiag_oe_in(poe),
        .dasp_n_out(dasp_w), .pdiag_n_out(pdiag_w));
    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr_en <= w;
        rd_en <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask : bus
    task automatic run(input logic s, p, q, k, input int lo, hi, input logic [7:0] err);
        bus(1, hrs_pkg::REG_MODE, 32'h0155_01AB);
        sel <= s;
        prs <= p;
        ps <= q;
        hw_n <= 1'b0;
        srst_seen = 0;
        dst_seen = 0;
        repeat (5000) @(posedge clk);
        hw_n <= 1'b1;
        t0 = cyc;
        bus(1, hrs_pkg::REG_STATUS, 32'h0000_007F);
        bus(1, hrs_pkg::REG_DEVCTL, 32'h0000_0114);
        chk("release", {bsy, rel}, 2'b11);
        do bus(0, hrs_pkg::REG_STATUS, 0); while (rdd[10:8] !== 3'h7);
        chk("wait", 32'(cyc - t0 >= lo && cyc - t0 < hi), 1);
        chk("dasp", {doe, dn}, s ? 2'b10 : 2'b01);
        bus(1, hrs_pkg::REG_CONFIG, {17'h0, 7'h15, 5'h0, q, 1'b1, k});
        for (int i = 0; i < 50 && bsy !== 1'b0; i++) @(posedge clk);
        chk("busy", {bsy, rel}, 0);
        bus(0, hrs_pkg::REG_ERROR, 0);
        chk("error", rdd, {24'h0, err | 8'h15});
        bus(0, hrs_pkg::REG_STATUS, 0);
        chk("status", rdd[7:0], k ? 8'h02 : 8'h72);
        bus(0, hrs_pkg::REG_DEVCTL, 0);
        chk("devctl", rdd & 32'h0000_0014, 0);
        bus(0, hrs_pkg::REG_MODE, 0);
        chk("udma", rdd, k ? 32'h0155_0055 : 32'h0155_00AB);
        bus(0, hrs_pkg::REG_IDW93, 0);
        chk("word93", rdd, {27'h0, !s && p && q, !s && p, q, s, 1'b1});
        bus(0, hrs_pkg::REG_SIG, 0);
        chk("sig", rdd, k ? 2 : 1);
        chk("pulses", {srst_seen, dst_seen}, 2'b01);
        if (s) chk("pdiag", {poe, pn}, {1'b1, !q});
    endtask : run
    task automatic report_and_stop();
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    // ==========================================================
    // Sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("reset", {bsy, rel, doe, poe}, 4'hC);
        be <= 4'h1;
        bus(1, hrs_pkg::REG_MODE, 32'h0000_01AB);
        be <= 4'hF;
        bus(0, hrs_pkg::REG_MODE, 0);
        chk("lanes", rdd, 32'h0000_00AB);
        bus(0, 6'h3C, 0);
        chk("unmapped", rdd, 0);
        run(0, 0, 0, 0, 3900, 4400, 8'h00);
        hw_n <= 1'b0;
        @(posedge clk);
        hw_n <= 1'b1;
        repeat (20) @(posedge clk);
        chk("glitch", bsy, 0);
        run(0, 1, 1, 0, 3000, 3400, 8'h00);
        hw_n <= 1'b0;
        repeat (5000) @(posedge clk);
        hw_n <= 1'b1;
        repeat (2000) @(posedge clk);
        run(0, 1, 0, 0, 7900, 8400, 8'h80);
        run(1, 0, 1, 1, 0, 400, 8'h00);
        srst_seen = 0;
        bus(1, hrs_pkg::REG_DEVCTL, 32'h0000_0004);
        bus(0, hrs_pkg::REG_DEVCTL, 0);
        chk("soft", {srst_seen, rdd[4:2]}, 4'h9);
        run(1, 0, 0, 0, 0, 400, 8'h00);
        report_and_stop();
    end
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule : test_hrs_seq
